// *** hw/php_device.sv ***
// device end of the parallel host port; fills two audio input fifos
// assumes host pins are asynchronous; the dsp side runs on i_clk_sys
//
// Overview of operation
// - byte port, separate strobes or data strobe
// - address 00 message, 01 control
// - address 10 linear, 11 compressed, write-only
// - inbound and outbound message bytes are separate
// - message accesses move the handshake flags
// - inbound pending: set host write, cleared dsp read
// - outbound ready: set dsp write, cleared host read
// - control bit 6 resets compressed channel
// - control bit 5 resets linear channel
// - bit 4 shows linear fifo almost full
// - bit 3 shows compressed fifo almost full
// - host writes zero to reserved bits
// - audio writes push fifo unless its channel is held in reset; never read back
// - host polls flags before message bytes
// - data pins shared; no external memory
// - multibyte messages, one byte per handshake
// - interrupt low while outbound byte pending, if enabled
// - separate-strobe write sequence by host
// - separate-strobe read sequence by host
// - data-strobe style with direction select
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// device end
// ************************************************************
module php_device
  import php_pkg::*;
#(
  parameter int AF_LEVEL = FIFO_AF_LEVEL,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk_sys,            // system clock
  input wire logic i_rst_b,              // sync reset, active low
  php_if.device bus,                     // host pins
  input wire logic i_bus_style,          // STYLE_SEP or STYLE_DS
  input wire logic i_notify_en,          // firmware enables interrupt
  input wire logic [7:0] i_dsp_out_byte, // outbound byte from dsp
  input wire logic i_dsp_out_wr,         // dsp writes outbound byte
  input wire logic i_dsp_in_rd,          // dsp has read inbound byte
  output logic [7:0] o_in_byte,          // inbound byte for dsp
  output logic o_in_pending,             // inbound byte pending
  output logic o_out_ready,              // outbound byte not yet read
  output logic o_lin_rst,                // linear channel held in reset
  output logic o_cmp_rst,                // compressed channel held in reset
  output logic [7:0] o_lin_data,         // linear fifo head
  output logic o_lin_valid,              // linear fifo not empty
  input wire logic i_lin_ready,          // dsp takes linear word
  output logic [7:0] o_cmp_data,         // compressed fifo head
  output logic o_cmp_valid,              // compressed fifo not empty
  input wire logic i_cmp_ready           // dsp takes compressed word
);
  localparam int PW = 13;
  localparam int LW = $clog2(DEPTH + 1);
  logic [PW-1:0] s1_q, s2_q, s3_q, f_q;
  logic wr_act_q, rd_act_q;
  logic [1:0] cap_addr_q;
  logic [7:0] cap_data_q;
  logic in_pend_q, out_rdy_q, lin_rst_q, cmp_rst_q, lin_af_q, cmp_af_q;
  logic [7:0] in_byte_q, out_byte_q, dev_d_q;
  logic dev_oe_q, irq_n_q;
  logic lin_pend_q, cmp_pend_q;
  logic [7:0] lin_hold_q, cmp_hold_q;
  logic lin_rdy, cmp_rdy;
  logic [LW-1:0] lin_lvl, cmp_lvl;

  // a bit changes once the second and third stages agree
  wire [PW-1:0] pin_raw = {bus.cs_n, bus.stb_a_n, bus.stb_b, bus.addr, bus.data};
  wire [PW-1:0] f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      f_q <= '1;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // strobe decode for either bus style
  wire cs_act = !f_q[12];
  wire a_n = f_q[11];
  wire b_lvl = f_q[10];
  wire [1:0] p_addr = f_q[9:8];
  wire sep = i_bus_style == STYLE_SEP;
  wire wr_act = cs_act && (sep ? !a_n : (!a_n && !b_lvl));
  wire rd_act = cs_act && (sep ? !b_lvl : (!a_n && b_lvl));
  wire wr_done = wr_act_q && !wr_act;
  wire rd_done = rd_act_q && !rd_act;

  // register selects on the completed access
  wire msg_w = wr_done && cap_addr_q == ADDR_MSG;
  wire ctrl_w = wr_done && cap_addr_q == ADDR_CTRL;
  wire lin_w = wr_done && cap_addr_q == ADDR_LIN;
  wire cmp_w = wr_done && cap_addr_q == ADDR_CMP;
  wire msg_r = rd_done && cap_addr_q == ADDR_MSG;

  // read value; write-only and reserved bits read zero
  wire [7:0] ctrl_rd = {3'h0, lin_af_q, cmp_af_q, in_pend_q, out_rdy_q, 1'b0};
  wire [7:0] rd_mux = (p_addr == ADDR_MSG) ? out_byte_q :
                      (p_addr == ADDR_CTRL) ? ctrl_rd : 8'h00;

  // access tracking and capture while the strobe is held
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      cap_addr_q <= 2'h0;
      cap_data_q <= 8'h00;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act || rd_act)
      begin
        cap_addr_q <= p_addr;
        cap_data_q <= f_q[7:0];
      end
    end
  end

  // message bytes and handshake flags; a set wins over a clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      in_byte_q <= 8'h00;
      out_byte_q <= 8'h00;
      in_pend_q <= 1'b0;
      out_rdy_q <= 1'b0;
    end
    else
    begin
      if (msg_w)
        in_byte_q <= cap_data_q;
      if (i_dsp_out_wr)
        out_byte_q <= i_dsp_out_byte;
      if (msg_w)
        in_pend_q <= 1'b1;
      else if (i_dsp_in_rd)
        in_pend_q <= 1'b0;
      if (i_dsp_out_wr)
        out_rdy_q <= 1'b1;
      else if (msg_r)
        out_rdy_q <= 1'b0;
    end
  end

  // channel reset bits and almost-full flags
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      lin_rst_q <= CTRL_RST_RESET;
      cmp_rst_q <= CTRL_RST_RESET;
      lin_af_q <= 1'b0;
      cmp_af_q <= 1'b0;
    end
    else
    begin
      if (ctrl_w)
      begin
        cmp_rst_q <= cap_data_q[CTRL_CMP_RST];
        lin_rst_q <= cap_data_q[CTRL_LIN_RST];
      end
      lin_af_q <= lin_lvl >= LW'(AF_LEVEL);
      cmp_af_q <= cmp_lvl >= LW'(AF_LEVEL);
    end
  end

  // audio bytes wait here until their fifo has room
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      lin_pend_q <= 1'b0;
      cmp_pend_q <= 1'b0;
      lin_hold_q <= 8'h00;
      cmp_hold_q <= 8'h00;
    end
    else
    begin
      if (lin_w)
        lin_hold_q <= cap_data_q;
      if (cmp_w)
        cmp_hold_q <= cap_data_q;
      if (lin_w)
        lin_pend_q <= !lin_rst_q;
      else if (lin_rdy || lin_rst_q)
        lin_pend_q <= 1'b0;
      if (cmp_w)
        cmp_pend_q <= !cmp_rst_q;
      else if (cmp_rdy || cmp_rst_q)
        cmp_pend_q <= 1'b0;
    end
  end

  // data pins driven only during a read; interrupt mirrors ready flag when enabled
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      dev_d_q <= 8'h00;
      dev_oe_q <= 1'b0;
      irq_n_q <= 1'b1;
    end
    else
    begin
      dev_d_q <= rd_mux;
      dev_oe_q <= rd_act;
      irq_n_q <= !(i_notify_en && out_rdy_q);
    end
  end

  audio_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_lin_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_srst(lin_rst_q),
    .i_valid(lin_pend_q),
    .i_data(lin_hold_q),
    .o_ready(lin_rdy),
    .o_valid(o_lin_valid),
    .o_data(o_lin_data),
    .i_ready(i_lin_ready),
    .o_level(lin_lvl)
  );

  audio_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_cmp_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_srst(cmp_rst_q),
    .i_valid(cmp_pend_q),
    .i_data(cmp_hold_q),
    .o_ready(cmp_rdy),
    .o_valid(o_cmp_valid),
    .o_data(o_cmp_data),
    .i_ready(i_cmp_ready),
    .o_level(cmp_lvl)
  );

  // pins and user outputs from flops
  assign bus.dev_d = dev_d_q;
  assign bus.dev_oe = dev_oe_q;
  assign bus.message_interrupt_n = irq_n_q;
  assign o_in_byte = in_byte_q;
  assign o_in_pending = in_pend_q;
  assign o_out_ready = out_rdy_q;
  assign o_lin_rst = lin_rst_q;
  assign o_cmp_rst = cmp_rst_q;
endmodule : php_device

`default_nettype wire

// *** hw/php_pkg.sv ***
// constants shared by both ends of the byte-wide parallel host port
// assumes one system clock; the host-side strobes are asynchronous to it
package php_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [1:0] ADDR_MSG = 2'h0;   // message byte register
  localparam logic [1:0] ADDR_CTRL = 2'h1;  // handshake control/status
  localparam logic [1:0] ADDR_LIN = 2'h2;   // linear audio input
  localparam logic [1:0] ADDR_CMP = 2'h3;   // compressed audio input

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_CMP_RST = 6;
  localparam int CTRL_LIN_RST = 5;
  localparam int CTRL_LIN_AF = 4;
  localparam int CTRL_CMP_AF = 3;
  localparam int CTRL_IN_PEND = 2;
  localparam int CTRL_OUT_RDY = 1;
  localparam logic [7:0] CTRL_RESV_MASK = 8'h81;  // bits 7 and 0
  localparam logic CTRL_RST_RESET = 1'b0;          // channel resets released after reset

  // ************************************************************
  // bus styles and timing
  // ************************************************************
  localparam logic STYLE_SEP = 1'b0;  // separate read and write strobes
  localparam logic STYLE_DS = 1'b1;   // data strobe plus direction select
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AF_LEVEL = 3;   // almost-full threshold in words
  localparam int HOLD_CYC = 12;       // host phase length in clocks

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RECOVER} host_state_t;

endpackage : php_pkg

// *** hw/php_if.sv ***
// pins between the host and the device of the parallel host port
// assumes each end drives its data enable only while it owns the bus
`timescale 1ns/1ps
`default_nettype none

interface php_if;
  logic cs_n;                 // chip select
  logic stb_a_n;              // write strobe, or data_strobe_n
  logic stb_b;                // read strobe (low), or direction (high = read)
  logic [1:0] addr;           // register address
  logic [7:0] host_d;         // host data out
  logic host_oe;              // host drives data
  logic [7:0] dev_d;          // device data out
  logic dev_oe;               // device drives data
  logic message_interrupt_n;  // outbound message pending, active low
  logic [7:0] data;           // resolved data pins

  // resolved level of the shared data pins, pulled high when idle
  assign data = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);

  modport device (
    input cs_n, stb_a_n, stb_b, addr, data,
    output dev_d, dev_oe, message_interrupt_n
  );
  modport host (
    input data, message_interrupt_n,
    output cs_n, stb_a_n, stb_b, addr, host_d, host_oe
  );
endinterface : php_if

`default_nettype wire

// *** hw/php_host.sv ***
// host end of the parallel host port: runs one byte access per request, after repeated control reads when polling
// also holds the generic audio fifo that the device end instantiates
// assumes the device pins are asynchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none

module php_host
  import php_pkg::*;
#(
  parameter int HOLD = HOLD_CYC
) (
  input wire logic i_clk_sys,      // system clock
  input wire logic i_rst_b,        // sync reset, active low
  php_if.host bus,                 // device pins
  input wire logic i_bus_style,    // STYLE_SEP or STYLE_DS
  input wire logic i_req,          // start an access
  input wire logic i_write,        // 1 write, 0 read
  input wire logic [1:0] i_addr,   // register address
  input wire logic [7:0] i_wdata,  // write byte
  input wire logic i_poll,         // poll flags before message bytes
  output logic o_busy,             // access in progress
  output logic o_done,             // access finished, one cycle
  output logic [7:0] o_rdata,      // last byte read
  output logic o_irq               // synchronised interrupt, active high
);
  host_state_t st_q, st_d;
  logic [7:0] cnt_q;
  logic poll_q, wr_q, busy_q, done_q;
  logic [1:0] addr_q, pa_q;
  logic [7:0] wdata_q, rdata_q, hd_q;
  logic cs_n_q, a_q, b_q, hoe_q;
  logic [8:0] s1_q, s2_q, s3_q, f_q;

  // inputs pass three stages, a bit changes once stages two and three agree
  wire [8:0] f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      f_q <= '1;
    end
    else
    begin
      s1_q <= {bus.message_interrupt_n, bus.data};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // current access: a poll reads control, otherwise the request
  wire tick = cnt_q == 8'(HOLD - 1);
  wire cur_wr = poll_q ? 1'b0 : wr_q;
  wire [1:0] cur_addr = poll_q ? ADDR_CTRL : addr_q;
  wire poll_ok = wr_q ? !rdata_q[CTRL_IN_PEND] : rdata_q[CTRL_OUT_RDY];
  wire sep = i_bus_style == STYLE_SEP;
  wire strobe_on = st_d == H_STROBE;

  // phase sequencer
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      H_IDLE: if (i_req) st_d = H_SETUP;
      H_SETUP: if (tick) st_d = H_STROBE;
      H_STROBE: if (tick) st_d = H_RECOVER;
      H_RECOVER: if (tick) st_d = poll_q ? H_SETUP : H_IDLE;
    endcase
  end

  // request, poll and sample state
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      st_q <= H_IDLE;
      cnt_q <= 8'h00;
      poll_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 2'h0;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? 8'h00 : cnt_q + 8'h01;
      busy_q <= st_d != H_IDLE;
      done_q <= st_q == H_RECOVER && tick && !poll_q;
      if (st_q == H_IDLE && i_req)
      begin
        wr_q <= i_write;
        addr_q <= i_addr;
        wdata_q <= i_wdata;
        poll_q <= i_poll && i_addr == ADDR_MSG;
      end
      if (st_q == H_STROBE && tick && !cur_wr)
        rdata_q <= f_q[7:0];
      if (st_q == H_RECOVER && tick && poll_q)
        poll_q <= !poll_ok;
    end
  end

  // pins follow the next phase so each comes from a flop
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      cs_n_q <= 1'b1;
      a_q <= 1'b1;
      b_q <= 1'b1;
      pa_q <= 2'h0;
      hd_q <= 8'h00;
      hoe_q <= 1'b0;
    end
    else
    begin
      pa_q <= cur_addr;
      cs_n_q <= !strobe_on;
      a_q <= !(strobe_on && (!sep || cur_wr));
      b_q <= sep ? !(strobe_on && !cur_wr) : !cur_wr;
      hd_q <= (cur_addr == ADDR_CTRL) ? (wdata_q & ~CTRL_RESV_MASK) : wdata_q;
      hoe_q <= strobe_on && cur_wr;
    end
  end

  assign bus.cs_n = cs_n_q;
  assign bus.stb_a_n = a_q;
  assign bus.stb_b = b_q;
  assign bus.addr = pa_q;
  assign bus.host_d = hd_q;
  assign bus.host_oe = hoe_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rdata = rdata_q;
  assign o_irq = !f_q[8];
endmodule : php_host

// ************************************************************
// audio input fifo
// ************************************************************
module audio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH),
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic i_clk_sys,            // system clock
  input wire logic i_rst_b,              // sync reset, active low
  input wire logic i_srst,               // channel reset, active high
  input wire logic i_valid,              // fill side valid
  input wire logic [WIDTH-1:0] i_data,   // fill side data
  output logic o_ready,                  // room available
  output logic o_valid,                  // word available
  output logic [WIDTH-1:0] o_data,       // head word
  input wire logic i_ready,              // drain side ready
  output logic [LW-1:0] o_level          // words held
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [LW-1:0] cnt_q;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  // flags from the fill count
  assign o_ready = cnt_q != LW'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rp_q];
  assign o_level = cnt_q;

  // storage, no reset needed
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem_q[wp_q] <= i_data;
  end

  // pointers and count
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b || i_srst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + AW'(1);
      if (pop)
        rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + LW'(push) - LW'(pop);
    end
  end
endmodule : audio_fifo

`default_nettype wire

// *** sim/php_props.sv ***
// checker on the pins that join the host end to the device end
// assumes it is instantiated beside the php_if joining both ends
`timescale 1ns/1ps
`default_nettype none

module php_props
  import php_pkg::*;
(
  input wire logic i_clk_sys,            // system clock
  input wire logic i_rst_b,              // sync reset, active low
  input wire logic cs_n,                 // chip select
  input wire logic stb_a_n,              // write strobe or data strobe
  input wire logic [1:0] addr,           // register address
  input wire logic [7:0] host_d,         // host data out
  input wire logic host_oe,              // host drives data
  input wire logic dev_oe,               // device drives data
  input wire logic message_interrupt_n   // outbound pending, active low
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  logic msg_rd_q;

  // remembers a message-register read in progress
  always_ff @(posedge i_clk_sys)
    if (!i_rst_b)
      msg_rd_q <= 1'b0;
    else
      msg_rd_q <= !cs_n && !host_oe && addr == ADDR_MSG;

  // ************************************************************
  // pin relations
  // ************************************************************
  chk_no_contention: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the data pins");
  chk_resv_zero: assert property (host_oe && addr == ADDR_CTRL |->
    (host_d & CTRL_RESV_MASK) == 8'h00) else $error("reserved bit written as one");
  chk_oe_framed: assert property (host_oe |-> !cs_n)
    else $error("host drives data outside a cycle");
  chk_idle_strobe: assert property (cs_n |-> stb_a_n)
    else $error("strobe low while deselected");
  chk_strobe_width: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("strobe too short");
  chk_addr_stable: assert property (!cs_n && !$past(cs_n) |-> $stable(addr))
    else $error("address moved during a cycle");
  chk_read_addr: assert property (!cs_n && !host_oe |-> !addr[1])
    else $error("read of a write-only address");
  chk_read_answer: assert property ($fell(cs_n) && !host_oe |-> ##[1:8] dev_oe)
    else $error("device gave no read data");
  chk_drive_release: assert property ($rose(cs_n) |-> ##[1:8] !dev_oe)
    else $error("device kept driving after the cycle");
  chk_irq_clear: assert property ($rose(cs_n) && msg_rd_q |->
    ##[1:8] message_interrupt_n) else $error("interrupt stayed low after read");
endmodule : php_props

`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench: host end and device end joined by one php_if
// assumes php_pkg, php_if, php_device, php_host and php_props are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench
  import php_pkg::*;
;
  logic i_clk_sys, i_rst_b, style, notify, out_wr, in_rd, lin_ready, cmp_ready;
  logic req, wr, poll, busy, done, irq, in_pend, out_rdy, lin_rst, cmp_rst;
  logic lin_valid, cmp_valid;
  logic [7:0] out_byte, wdata, rdata, in_byte, lin_data, cmp_data;
  logic [1:0] addr;
  int n_errors, checks_done;

  php_if bus_if ();
  php_device #(.AF_LEVEL(FIFO_AF_LEVEL), .DEPTH(FIFO_DEPTH)) php_device_inst (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .bus(bus_if), .i_bus_style(style),
    .i_notify_en(notify), .i_dsp_out_byte(out_byte), .i_dsp_out_wr(out_wr),
    .i_dsp_in_rd(in_rd), .o_in_byte(in_byte), .o_in_pending(in_pend),
    .o_out_ready(out_rdy), .o_lin_rst(lin_rst), .o_cmp_rst(cmp_rst),
    .o_lin_data(lin_data), .o_lin_valid(lin_valid), .i_lin_ready(lin_ready),
    .o_cmp_data(cmp_data), .o_cmp_valid(cmp_valid), .i_cmp_ready(cmp_ready));
  php_host php_host_inst (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .bus(bus_if), .i_bus_style(style),
    .i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata), .i_poll(poll),
    .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_irq(irq));
  php_props php_props_inst (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .cs_n(bus_if.cs_n),
    .stb_a_n(bus_if.stb_a_n), .addr(bus_if.addr), .host_d(bus_if.host_d),
    .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe),
    .message_interrupt_n(bus_if.message_interrupt_n));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one host access; waits for the done pulse under a bound
  task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
                        input logic p);
    int k;
    @(posedge i_clk_sys) #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    poll = p;
    @(posedge i_clk_sys) #1;
    req = 1'b0;
    chk(8'(busy), 8'h01);
    k = 0;
    while (done !== 1'b1 && k < 4000)
    begin
      @(posedge i_clk_sys) #1;
      k++;
    end
    if (k >= 4000)
      n_errors++;
    chk(8'(busy), 8'h00);
  endtask : access

  // dsp side pulses
  task automatic dsp_pulse(input logic rd, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    out_byte = d;
    in_rd = rd;
    out_wr = !rd;
    @(posedge i_clk_sys) #1;
    in_rd = 1'b0;
    out_wr = 1'b0;
  endtask : dsp_pulse

  // takes one word from a fifo, then stalls the far side
  task automatic drain(input int c, output logic [7:0] d);
    int k;
    k = 0;
    while ((c ? cmp_valid : lin_valid) !== 1'b1 && k < 50)
    begin
      @(posedge i_clk_sys) #1;
      k++;
    end
    d = c ? cmp_data : lin_data;
    cmp_ready = c[0];
    lin_ready = !c[0];
    @(posedge i_clk_sys) #1;
    cmp_ready = 1'b0;
    lin_ready = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : drain

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_msg_in;
    for (int s = 0; s < 2; s++)
    begin
      style = s[0];
      access(1'b1, ADDR_MSG, s ? 8'ha5 : 8'h5a, 1'b0);
      chk(in_byte, s ? 8'ha5 : 8'h5a);
      chk(8'(in_pend), 8'h01);
      access(1'b0, ADDR_CTRL, 8'h00, 1'b0);
      chk(rdata, 8'h04);
      dsp_pulse(1'b1, 8'h00);
      chk(8'(in_pend), 8'h00);
    end
  endtask : t_msg_in

  task automatic t_msg_out;
    for (int s = 0; s < 2; s++)
    begin
      style = s[0];
      notify = s[0];
      dsp_pulse(1'b0, s ? 8'hc3 : 8'h3c);
      repeat (3) @(posedge i_clk_sys);
      #1;
      chk(8'(bus_if.message_interrupt_n), 8'(1 - s));
      access(1'b0, ADDR_CTRL, 8'h00, 1'b0);
      chk(rdata, 8'h02);
      chk(8'(irq), 8'(s));
      access(1'b0, ADDR_MSG, 8'h00, 1'b0);
      chk(rdata, s ? 8'hc3 : 8'h3c);
      chk(8'(irq), 8'h00);
      chk(8'(out_rdy), 8'h00);
      chk(8'(bus_if.message_interrupt_n), 8'h01);
    end
  endtask : t_msg_out

  task automatic t_poll;
    access(1'b1, ADDR_MSG, 8'h11, 1'b0);
    fork
      access(1'b1, ADDR_MSG, 8'h22, 1'b1);
      begin
        repeat (150) @(posedge i_clk_sys);
        #1;
        chk(in_byte, 8'h11);
        dsp_pulse(1'b1, 8'h00);
      end
    join
    chk(in_byte, 8'h22);
    dsp_pulse(1'b1, 8'h00);
    fork
      access(1'b0, ADDR_MSG, 8'h00, 1'b1);
      begin
        repeat (150) @(posedge i_clk_sys);
        dsp_pulse(1'b0, 8'h77);
      end
    join
    chk(rdata, 8'h77);
  endtask : t_poll

  task automatic t_ctrl;
    access(1'b1, ADDR_CTRL, 8'hff, 1'b0);
    chk(8'({cmp_rst, lin_rst}), 8'h03);
    access(1'b0, ADDR_CTRL, 8'h00, 1'b0);
    chk(rdata, 8'h00);
    access(1'b1, ADDR_LIN, 8'h99, 1'b0);
    access(1'b1, ADDR_CMP, 8'h98, 1'b0);
    chk(8'({cmp_valid, lin_valid}), 8'h00);
    access(1'b1, ADDR_CTRL, 8'h40, 1'b0);
    chk(8'({cmp_rst, lin_rst}), 8'h02);
    access(1'b1, ADDR_CTRL, 8'h00, 1'b0);
    chk(8'({cmp_rst, lin_rst}), 8'h00);
  endtask : t_ctrl

  task automatic t_fifo;
    logic [7:0] v;
    for (int c = 0; c < 2; c++)
    begin
      for (int k = 0; k < 5; k++)
        access(1'b1, c ? ADDR_CMP : ADDR_LIN, 8'(16 * c + k + 1), 1'b0);
      access(1'b0, ADDR_CTRL, 8'h00, 1'b0);
      chk(rdata, c ? 8'h08 : 8'h10);
      for (int k = 0; k < 5; k++)
      begin
        drain(c, v);
        chk(v, 8'(16 * c + k + 1));
      end
      access(1'b0, ADDR_CTRL, 8'h00, 1'b0);
      chk(rdata, 8'h00);
    end
  endtask : t_fifo

  // ************************************************************
  // run control
  // ************************************************************
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // free-running system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // cuts a hang short
  initial
  begin
    #200000;
    n_errors++;
    results();
  end

  // reset, then the scenarios
  initial
  begin
    {i_rst_b, style, notify, out_wr, in_rd, lin_ready, cmp_ready} = 7'h00;
    {req, wr, poll, out_byte, wdata, addr} = 21'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk_sys);
    #1;
    i_rst_b = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_msg_in();
    t_msg_out();
    t_poll();
    t_ctrl();
    t_fifo();
    results();
  end
endmodule : testbench

`default_nettype wire
